// file: core/ptms_consts.svh
// constants of the pattern trigger mode select block
`ifndef PTMS_CONSTS_SVH
`define PTMS_CONSTS_SVH
// ****************************************
// register map
// ****************************************
`define PTMS_ADDR_W        3
`define PTMS_OFS_TRIG_SEL  3'h0
`define PTMS_OFS_MODE      3'h1
`define PTMS_OFS_NEXT_LO   3'h2
`define PTMS_OFS_NEXT_HI   3'h3
`define PTMS_OFS_ENA_LO    3'h4
`define PTMS_OFS_ENA_HI    3'h5
`define PTMS_OFS_PORT_LO   3'h6
`define PTMS_OFS_PORT_HI   3'h7
// ****************************************
// reset values and fields
// ****************************************
`define PTMS_TRIG_SEL_RST  8'hff
`define PTMS_MODE_RST      8'hf0
`define PTMS_MODE_RSVD     8'hf0
`define PTMS_ZERO8         8'h00
`define PTMS_SEL_W         2
`define PTMS_NUM_GRP       4
`define PTMS_NUM_CHAN      4
`endif

// file: core/ptms_pkg.sv
// types of the pattern trigger mode select block
package ptms_pkg;
    typedef struct packed {
        logic [3:0] match_a;
        logic [3:0] match_b;
    } ptms_events_s;
    typedef logic [3:0] ptms_nib_t;
endpackage

// file: core/ptms_chan_decode.sv
// one-hot decode of a group's two channel select bits
`timescale 1ns/1ns
`default_nettype none
module ptms_chan_decode (
    // select code
    input  wire logic [1:0] i_sel,
    // one-hot channel choice
    output logic      [3:0] o_onehot
);
    assign o_onehot = 4'h1 << i_sel;
endmodule
`default_nettype wire

// file: core/ptms_group_update.sv
// next value of one four-pin group of port data
`timescale 1ns/1ns
`default_nettype none
module ptms_group_update (
    // trigger and mode
    input  wire logic       i_hit_a,
    input  wire logic       i_hit_b,
    input  wire logic       i_nonoverlap,
    // data
    input  wire logic [3:0] i_next,
    input  wire logic [3:0] i_enable,
    input  wire logic [3:0] i_port,
    output logic      [3:0] o_port
);
    wire logic [3:0] copy_a;
    wire logic [3:0] copy_b;
    wire logic [3:0] copy_m;
    assign copy_a = {4{i_hit_a}} & i_enable;
    assign copy_b = {4{i_hit_b & i_nonoverlap}} & i_enable & ~i_next;
    assign copy_m = copy_a | copy_b;
    assign o_port = (copy_m & i_next) | (~copy_m & i_port);
endmodule
`default_nettype wire

// file: core/ptms_top.sv
// pattern trigger mode select: registers, trigger routing and port data
`timescale 1ns/1ns
`default_nettype none
`include "ptms_consts.svh"
module ptms_top (
    // clock and reset
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_reset,
    input  wire logic                     i_hw_standby,
    // register port
    input  wire logic [`PTMS_ADDR_W-1:0]  i_addr,
    input  wire logic [7:0]               i_wdata,
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    output logic      [7:0]               o_rdata,
    // timer channel compare events
    input  wire ptms_pkg::ptms_events_s   i_events,
    // pattern pins
    output logic      [15:0]              o_pattern_pin,
    output logic      [3:0]               o_group_update
);
    // ****************************************
    // registers
    // ****************************************
    logic [7:0]  trig_sel_q;
    logic [3:0]  mode_q;
    logic [15:0] next_q;
    logic [15:0] ena_q;
    logic [15:0] port_q;
    logic [15:0] port_d;
    logic [7:0]  rdata_q;
    logic [3:0]  upd_q;

    wire logic        clr;
    wire logic        wr_sel;
    wire logic        wr_mode;
    wire logic [7:0]  rd_mux;
    wire logic [3:0]  grp_hit_a;
    wire logic [3:0]  grp_hit_b;

    // standby behaves as reset; software standby is not an input, so nothing clears
    assign clr     = i_reset | i_hw_standby;
    assign wr_sel  = i_wr & (i_addr == `PTMS_OFS_TRIG_SEL);
    assign wr_mode = i_wr & (i_addr == `PTMS_OFS_MODE);

    always_ff @(posedge i_sys_clk) begin
        if (clr) begin
            trig_sel_q <= `PTMS_TRIG_SEL_RST;
        end else if (wr_sel) begin
            trig_sel_q <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (clr) begin
            mode_q <= 4'(`PTMS_MODE_RST & 8'h0f);
        end else if (wr_mode) begin
            mode_q <= i_wdata[3:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (clr) begin
            next_q <= 16'h0000;
            ena_q  <= 16'h0000;
        end else if (i_wr) begin
            if (i_addr == `PTMS_OFS_NEXT_LO) begin
                next_q[7:0] <= i_wdata;
            end
            if (i_addr == `PTMS_OFS_NEXT_HI) begin
                next_q[15:8] <= i_wdata;
            end
            if (i_addr == `PTMS_OFS_ENA_LO) begin
                ena_q[7:0] <= i_wdata;
            end
            if (i_addr == `PTMS_OFS_ENA_HI) begin
                ena_q[15:8] <= i_wdata;
            end
        end
    end

    // ****************************************
    // trigger routing per group
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `PTMS_NUM_GRP; g = g + 1) begin : gen_grp
            wire logic [3:0] onehot;
            ptms_chan_decode u_dec (
                .i_sel    (trig_sel_q[2*g+1:2*g]),
                .o_onehot (onehot)
            );
            assign grp_hit_a[g] = |(onehot & i_events.match_a);
            assign grp_hit_b[g] = |(onehot & i_events.match_b);
            ptms_group_update u_upd (
                .i_hit_a      (grp_hit_a[g]),
                .i_hit_b      (grp_hit_b[g]),
                .i_nonoverlap (mode_q[g]),
                .i_next       (next_q[4*g+3:4*g]),
                .i_enable     (ena_q[4*g+3:4*g]),
                .i_port       (port_q[4*g+3:4*g]),
                .o_port       (port_d[4*g+3:4*g])
            );
        end
    endgenerate

    // port data: software write loses to a trigger copy in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (clr) begin
            port_q <= 16'h0000;
        end else begin
            port_q <= port_d;
            if (i_wr && i_addr == `PTMS_OFS_PORT_LO) begin
                port_q[7:0] <= (i_wdata & ~ena_q[7:0]) | (port_d[7:0] & ena_q[7:0]);
            end
            if (i_wr && i_addr == `PTMS_OFS_PORT_HI) begin
                port_q[15:8] <= (i_wdata & ~ena_q[15:8]) | (port_d[15:8] & ena_q[15:8]);
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (clr) begin
            upd_q <= 4'h0;
        end else begin
            upd_q <= grp_hit_a | (grp_hit_b & mode_q);
        end
    end

    // ****************************************
    // read back
    // ****************************************
    assign rd_mux = (i_addr == `PTMS_OFS_TRIG_SEL) ? trig_sel_q :
                    (i_addr == `PTMS_OFS_MODE)     ? (`PTMS_MODE_RSVD | {4'h0, mode_q}) :
                    (i_addr == `PTMS_OFS_NEXT_LO)  ? next_q[7:0] :
                    (i_addr == `PTMS_OFS_NEXT_HI)  ? next_q[15:8] :
                    (i_addr == `PTMS_OFS_ENA_LO)   ? ena_q[7:0] :
                    (i_addr == `PTMS_OFS_ENA_HI)   ? ena_q[15:8] :
                    (i_addr == `PTMS_OFS_PORT_LO)  ? port_q[7:0] :
                                                     port_q[15:8];

    always_ff @(posedge i_sys_clk) begin
        if (clr) begin
            rdata_q <= `PTMS_ZERO8;
        end else if (i_rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= `PTMS_ZERO8;
        end
    end

    assign o_rdata        = rdata_q;
    assign o_pattern_pin  = port_q;
    assign o_group_update = upd_q;

    // ****************************************
    // checks
    // ****************************************
    sel_reset_a : assert property (@(posedge i_sys_clk) clr |=> trig_sel_q == 8'hff)
        else $error("trigger select not ff after reset");
    mode_read_a : assert property (@(posedge i_sys_clk) disable iff (clr)
        $past(i_rd) && $past(i_addr) == 3'h1 |-> o_rdata[7:4] == 4'hf)
        else $error("mode reserved bits not one");
    sel_write_a : assert property (@(posedge i_sys_clk) disable iff (clr)
        wr_sel |=> trig_sel_q == $past(i_wdata))
        else $error("trigger select write lost");
    mode_reset_a : assert property (@(posedge i_sys_clk) clr |=> mode_q == 4'h0)
        else $error("mode not cleared");
    hold_idle_a : assert property (@(posedge i_sys_clk) disable iff (clr)
        !i_wr && i_events == '0 |=> o_pattern_pin == $past(o_pattern_pin))
        else $error("pins moved with no trigger");
    normal_b_a : assert property (@(posedge i_sys_clk) disable iff (clr)
        !i_wr && !mode_q[0] && !grp_hit_a[0] |=> o_pattern_pin[3:0] == $past(o_pattern_pin[3:0]))
        else $error("normal group moved without match A");
    copy_a_a : assert property (@(posedge i_sys_clk) disable iff (clr)
        grp_hit_a[0] && !i_wr
        |=> o_pattern_pin[3:0] == (($past(next_q[3:0]) & $past(ena_q[3:0]))
                                   | ($past(o_pattern_pin[3:0]) & ~$past(ena_q[3:0]))))
        else $error("match A did not copy");
    nov_b_a : assert property (@(posedge i_sys_clk) disable iff (clr)
        grp_hit_b[0] && !grp_hit_a[0] && mode_q[0] && !i_wr
        |=> o_pattern_pin[3:0] == ($past(o_pattern_pin[3:0]) & ($past(next_q[3:0]) | ~$past(ena_q[3:0]))))
        else $error("match B copied ones");
    port_write_a : assert property (@(posedge i_sys_clk) disable iff (clr)
        i_wr && i_addr == `PTMS_OFS_PORT_LO && i_events == '0
        |=> o_pattern_pin[7:0] == (($past(i_wdata) & ~$past(ena_q[7:0]))
                                   | ($past(o_pattern_pin[7:0]) & $past(ena_q[7:0]))))
        else $error("port write reached enabled bits");
    update_flag_a : assert property (@(posedge i_sys_clk) disable iff (clr)
        grp_hit_a == 4'hf |=> o_group_update == 4'hf)
        else $error("update flags missing");
endmodule
`default_nettype wire

// file: verif/ptms_timer_model.sv
// timer channel compare match source for the pattern trigger bench
`timescale 1ns/1ns
`default_nettype none
module ptms_timer_model (
    // clock
    input  wire logic              i_sys_clk,
    // requested events, one bit a channel
    input  wire logic [3:0]        i_req_a,
    input  wire logic [3:0]        i_req_b,
    // one-cycle compare match pulses
    output var ptms_pkg::ptms_events_s o_events
);
    // ****************************************
    // b closes the period, a ends the margin
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        o_events.match_a <= i_req_a;
        o_events.match_b <= i_req_b;
    end
endmodule
`default_nettype wire

// file: verif/pattern_trigger_mode_select_tb.sv
// self-checking bench of the pattern trigger mode select block
`timescale 1ns/1ns
`default_nettype none
`include "ptms_consts.svh"
module pattern_trigger_mode_select_tb;
    logic                   i_sys_clk = 1'b0;
    logic                   i_reset = 1'b1;
    logic                   i_hw_standby = 1'b0;
    logic [2:0]             i_addr = 3'h0;
    logic [7:0]             i_wdata = 8'h00;
    logic                   i_wr = 1'b0;
    logic                   i_rd = 1'b0;
    logic [7:0]             o_rdata;
    logic [15:0]            o_pattern_pin;
    logic [3:0]             o_group_update;
    logic [3:0]             req_a = 4'h0;
    logic [3:0]             req_b = 4'h0;
    ptms_pkg::ptms_events_s ev;
    logic [15:0]            exp_pin = 16'h0000;
    logic [15:0]            ena = 16'h7777;
    logic [7:0]             sel = 8'hff;
    logic [3:0]             mode = 4'h0;
    int                     error_cnt = 0;
    int                     checked = 0;

    always #50 i_sys_clk = ~i_sys_clk;

    ptms_timer_model timer (.i_sys_clk(i_sys_clk), .i_req_a(req_a), .i_req_b(req_b), .o_events(ev));
    ptms_top dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_hw_standby(i_hw_standby), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_events(ev),
        .o_pattern_pin(o_pattern_pin), .o_group_update(o_group_update));

    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge i_sys_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 check("rdata", {8'h00, o_rdata}, {8'h00, exp});
    endtask
    task automatic standby();
        @(posedge i_sys_clk) i_hw_standby <= 1'b1;
        @(posedge i_sys_clk) i_hw_standby <= 1'b0;
        mode = 4'h0;
        sel = 8'hff;
        exp_pin = 16'h0000;
    endtask
    // fires events and predicts each group from its select and mode
    task automatic fire(input logic [3:0] a, input logic [3:0] b, input logic [15:0] nv);
        logic [3:0] upd;
        logic [1:0] ch;
        wr(`PTMS_OFS_NEXT_LO, nv[7:0]);
        wr(`PTMS_OFS_NEXT_HI, nv[15:8]);
        for (int g = 0; g < 4; g++) begin
            ch = sel[2*g +: 2];
            upd[g] = a[ch] | (b[ch] & mode[g]);
            if (a[ch])
                exp_pin[4*g +: 4] = (exp_pin[4*g +: 4] & ~ena[4*g +: 4]) | (nv[4*g +: 4] & ena[4*g +: 4]);
            else if (b[ch] & mode[g])
                exp_pin[4*g +: 4] = exp_pin[4*g +: 4] & ~(ena[4*g +: 4] & ~nv[4*g +: 4]);
        end
        @(posedge i_sys_clk);
        req_a <= a; req_b <= b;
        @(posedge i_sys_clk);
        req_a <= 4'h0; req_b <= 4'h0;
        @(posedge i_sys_clk);
        #1 check("group_update", {12'h000, o_group_update}, {12'h000, upd});
        check("pattern_pin", o_pattern_pin, exp_pin);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        rd_chk(`PTMS_OFS_TRIG_SEL, 8'hff);
        rd_chk(`PTMS_OFS_MODE, 8'hf0);
        wr(`PTMS_OFS_TRIG_SEL, 8'h5a);
        wr(`PTMS_OFS_MODE, 8'h0a);
        rd_chk(`PTMS_OFS_TRIG_SEL, 8'h5a);
        rd_chk(`PTMS_OFS_MODE, 8'hfa);
        wr(`PTMS_OFS_MODE, 8'h05);
        rd_chk(`PTMS_OFS_MODE, 8'hf5);
        standby();
        rd_chk(`PTMS_OFS_TRIG_SEL, 8'hff);
        rd_chk(`PTMS_OFS_MODE, 8'hf0);
        wr(`PTMS_OFS_ENA_LO, ena[7:0]);
        wr(`PTMS_OFS_ENA_HI, ena[15:8]);
        for (int r = 0; r < 4; r++) begin
            for (int g = 0; g < 4; g++)
                sel[2*g +: 2] = 2'(g + r);
            wr(`PTMS_OFS_TRIG_SEL, sel);
            for (int c = 0; c < 4; c++)
                fire(4'(1 << c), 4'h0, ~exp_pin ^ {4{4'(c + r)}});
            fire(4'h0, 4'hf, ~exp_pin);
        end
        mode = 4'h5;
        wr(`PTMS_OFS_MODE, {4'h0, mode});
        for (int c = 0; c < 4; c++) begin
            fire(4'h0, 4'(1 << c), exp_pin ^ 16'h5a3c);
            fire(4'(1 << c), 4'h0, exp_pin ^ 16'h5a3c);
        end
        fire(4'hf, 4'hf, ~exp_pin);
        test_done();
    end

    initial begin
        #(100 * 4000);
        error_cnt++;
        test_done();
    end
endmodule
`default_nettype wire
